/* File: hdl/sacl_control.sv */
// converter control logic: apb registers, clocking, sequencing, result formatting
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sacl_control #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator clock, asynchronous to pclk
	input wire logic oscillator_out_clock,
	// system stop mode request
	input wire logic stop_mode,
	// converter core
	output logic core_conv_tick,
	output logic core_start,
	output sacl_pkg::sacl_route_t core_route,
	input wire logic [9:0] core_result,
	input wire logic core_done,
	// completion interrupt request
	output logic conv_irq
);

	// register state
	logic done_irq_enable;
	logic continuous_convert;
	logic [4:0] input_channel_select;
	logic [7:0] conv_clock_config;
	logic conversion_done_flag;
	logic rd_lock;
	logic [7:0] result_high;
	logic [7:0] result_low;
	sacl_pkg::sacl_state_t state;
	logic [3:0] pre_cnt;
	logic [4:0] tick_cnt;
	logic osc_meta;
	logic osc_sync;
	logic osc_prev;

	// next values
	sacl_pkg::sacl_state_t next_state;
	logic next_done_flag;
	logic next_irq;
	logic next_lock;
	logic [3:0] next_pre_cnt;
	logic [4:0] next_tick_cnt;

	// result placement for each format
	function automatic logic [15:0] format_result(input logic [9:0] r,
		input sacl_pkg::sacl_fmt_t f);
		logic [15:0] v;
		v = 16'h0000;
		case (f)
			sacl_pkg::FMT_TRUNC: v = {8'h00, r[9:2]};
			sacl_pkg::FMT_RIGHT: v = {6'h00, r[9:8], r[7:0]};
			sacl_pkg::FMT_LEFT: v = {r[9:2], r[1:0], 6'h00};
			default: v = {~r[9], r[8:2], r[1:0], 6'h00};
		endcase
		return v;
	endfunction : format_result

	// prescaler terminal count from the divide field
	function automatic logic [3:0] div_term(input logic [2:0] p);
		logic [3:0] t;
		t = sacl_pkg::DIV16_TERM;
		if (!p[2])
		begin
			case (p[1:0])
				2'h0: t = sacl_pkg::DIV1_TERM;
				2'h1: t = sacl_pkg::DIV2_TERM;
				2'h2: t = sacl_pkg::DIV4_TERM;
				default: t = sacl_pkg::DIV8_TERM;
			endcase
		end
		return t;
	endfunction : div_term

	// apb phase and address decode
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable & pready;
	wire bus_wr = access_ph & pwrite;
	wire bus_rd = access_ph & ~pwrite;
	wire hit_scr = paddr == sacl_pkg::OFF_STATUS_CONTROL[ADDR_W-1:0];
	wire hit_hi = paddr == sacl_pkg::OFF_RESULT_HIGH[ADDR_W-1:0];
	wire hit_lo = paddr == sacl_pkg::OFF_RESULT_LOW[ADDR_W-1:0];
	wire hit_cfg = paddr == sacl_pkg::OFF_CLOCK_CONFIG[ADDR_W-1:0];
	wire hit_any = hit_scr | hit_hi | hit_lo | hit_cfg;
	wire scr_wr = bus_wr & hit_scr;
	wire cfg_wr = bus_wr & hit_cfg;
	wire hi_rd = bus_rd & hit_hi;
	wire lo_rd = bus_rd & hit_lo;
	wire data_rd = hi_rd | lo_rd;

	// configuration fields
	wire [2:0] prescale = conv_clock_config[sacl_pkg::CFG_DIV_MSB:sacl_pkg::CFG_DIV_LSB];
	wire conv_clock_source_sel = conv_clock_config[sacl_pkg::CFG_SRC_BIT];
	wire result_format_hi = conv_clock_config[sacl_pkg::CFG_FMT_MSB];
	wire result_format_lo = conv_clock_config[sacl_pkg::CFG_FMT_LSB];
	wire sacl_pkg::sacl_fmt_t fmt = sacl_pkg::sacl_fmt_t'({result_format_hi, result_format_lo});
	wire interlocked = fmt != sacl_pkg::FMT_TRUNC;
	wire powered_off = input_channel_select == sacl_pkg::CH_POWER_OFF;

	// done flag view: always zero while the interrupt is enabled
	wire done_view = conversion_done_flag & ~done_irq_enable;

	// read data mux
	wire [7:0] scr_view = {done_view, done_irq_enable, continuous_convert, input_channel_select};
	wire [7:0] rd_byte = hit_scr ? scr_view :
		hit_hi ? result_high :
		hit_lo ? result_low :
		hit_cfg ? conv_clock_config : 8'h00;

	// converter clock: input clock select then prescale
	wire osc_rise = osc_sync & ~osc_prev;
	wire in_tick = conv_clock_source_sel ? 1'b1 : osc_rise;
	wire [3:0] term = div_term(prescale);
	wire conv_tick = in_tick & (pre_cnt >= term);

	// conversion sequencing
	wire [4:0] wr_chan = pwdata[sacl_pkg::SCR_CHAN_MSB:0];
	wire start_req = scr_wr & (wr_chan != sacl_pkg::CH_POWER_OFF) & ~stop_mode;
	wire converting = state == sacl_pkg::ST_CONV;
	// the core sees each tick a cycle late, so wait one tick past its longest conversion
	wire last_tick = conv_tick & (tick_cnt == sacl_pkg::CONV_MAX_CYC);
	// the core's strobe ends a conversion; the cycle limit guards a silent core
	wire finish = converting & (core_done | last_tick);
	// a rewrite of scr with a channel other than power-off during a conversion discards it and starts afresh
	wire done_evt = finish & ~start_req & ~stop_mode;
	wire restart = done_evt & continuous_convert & ~powered_off;
	wire store = done_evt & ~(rd_lock & interlocked);
	// unused channel codes pass the core's result through unchecked
	wire [15:0] fmt_word = format_result(core_result, fmt);

	// next state of the sequencer
	always_comb
	begin
		next_state = state;
		if (stop_mode)
			next_state = sacl_pkg::ST_IDLE;
		else if (start_req)
			next_state = sacl_pkg::ST_CONV;
		else if (done_evt)
			next_state = restart ? sacl_pkg::ST_CONV : sacl_pkg::ST_IDLE;
	end

	// converter cycle counter within one conversion
	always_comb
	begin
		next_tick_cnt = tick_cnt;
		if (stop_mode || start_req || restart || !converting)
			next_tick_cnt = 5'h00;
		else if (conv_tick)
			next_tick_cnt = tick_cnt + 5'h01;
	end

	// prescaler counter
	always_comb
	begin
		next_pre_cnt = pre_cnt;
		if (stop_mode)
			next_pre_cnt = 4'h0;
		else if (in_tick)
			next_pre_cnt = conv_tick ? 4'h0 : pre_cnt + 4'h1;
	end

	// flags: a set in the same cycle as a clear wins
	always_comb
	begin
		next_done_flag = conversion_done_flag;
		if (done_irq_enable)
			next_done_flag = 1'b0;
		else if (done_evt)
			next_done_flag = 1'b1;
		else if (data_rd)
			next_done_flag = 1'b0;
		next_irq = (done_evt & done_irq_enable) | (conv_irq & ~(data_rd | scr_wr));
	end

	// read interlock between high and low result
	always_comb
	begin
		next_lock = rd_lock;
		if (!interlocked)
			next_lock = 1'b0;
		else if (lo_rd)
			next_lock = 1'b0;
		else if (hi_rd)
			next_lock = 1'b1;
	end

	// apb response, registered so outputs come from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup_ph;
			prdata <= setup_ph ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr <= setup_ph & ~hit_any;
		end
	end

	// status and control register; the done flag bit of a write is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_irq_enable <= 1'b0;
			continuous_convert <= 1'b0;
			input_channel_select <= sacl_pkg::CHAN_RESET;
		end
		else if (scr_wr)
		begin
			done_irq_enable <= pwdata[sacl_pkg::SCR_IRQ_EN_BIT];
			continuous_convert <= pwdata[sacl_pkg::SCR_CONT_BIT];
			input_channel_select <= wr_chan;
		end
	end

	// clock config register; the two low bits are reserved and read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_clock_config <= sacl_pkg::CFG_RESET;
		else if (cfg_wr)
			conv_clock_config <= {pwdata[7:2], 2'h0};
	end

	// oscillator clock synchroniser and edge history
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
		end
		else
		begin
			osc_meta <= oscillator_out_clock;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
		end
	end

	// sequencer and counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= sacl_pkg::ST_IDLE;
			tick_cnt <= 5'h00;
			pre_cnt <= 4'h0;
		end
		else
		begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			pre_cnt <= next_pre_cnt;
		end
	end

	// flags and interlock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conversion_done_flag <= 1'b0;
			conv_irq <= 1'b0;
			rd_lock <= 1'b0;
		end
		else
		begin
			conversion_done_flag <= next_done_flag;
			conv_irq <= next_irq;
			rd_lock <= next_lock;
		end
	end

	// result storage; new results overwrite unread data except while a high read holds the interlock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result_high <= 8'h00;
			result_low <= 8'h00;
		end
		else if (store)
		begin
			result_high <= fmt_word[15:8];
			result_low <= fmt_word[7:0];
		end
	end

	// core drive: tick, start pulse and routing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_conv_tick <= 1'b0;
			core_start <= 1'b0;
			core_route <= '0;
		end
		else
		begin
			core_conv_tick <= conv_tick & converting;
			core_start <= start_req | restart;
			core_route.power_on <= ~powered_off & ~stop_mode;
			core_route.sel_ext <= input_channel_select <= sacl_pkg::CH_EXT_LAST;
			core_route.sel_high_ref <= input_channel_select == sacl_pkg::CH_HIGH_REF;
			core_route.sel_low_ref <= input_channel_select == sacl_pkg::CH_LOW_REF;
			core_route.channel <= input_channel_select;
		end
	end

	// checks on the sequencing and register behaviour
	chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && !done_irq_enable |=> conversion_done_flag)
		else $error("done flag not set after conversion");
	chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
		conversion_done_flag && !done_irq_enable && !data_rd && !scr_wr |=> conversion_done_flag)
		else $error("done flag dropped without data read");
	chk_flag_zero: assert property (@(posedge pclk) disable iff (!presetn)
		done_irq_enable |-> !done_view)
		else $error("done flag visible with irq enabled");
	chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && done_irq_enable |=> conv_irq)
		else $error("irq not raised after conversion");
	chk_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(data_rd || scr_wr) && !done_evt |=> !conv_irq)
		else $error("irq not cleared by access");
	chk_single_idle: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt && !continuous_convert && !start_req |=> state == sacl_pkg::ST_IDLE)
		else $error("single conversion did not stop");
	chk_conv_bound: assert property (@(posedge pclk) disable iff (!presetn)
		converting |-> tick_cnt <= sacl_pkg::CONV_MAX_CYC)
		else $error("conversion ran past cycle limit");
	chk_power_off: assert property (@(posedge pclk) disable iff (!presetn)
		powered_off && $past(powered_off) |-> !core_route.power_on && !core_start)
		else $error("converter powered while channel off");
	chk_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
		rd_lock && interlocked && !lo_rd |=> $stable(result_low))
		else $error("low result changed while locked");
	chk_trunc_high: assert property (@(posedge pclk) disable iff (!presetn)
		store && fmt == sacl_pkg::FMT_TRUNC |=> result_high == 8'h00)
		else $error("high result nonzero in truncation");
	chk_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
		stop_mode |=> state == sacl_pkg::ST_IDLE && !core_start)
		else $error("sequencer active in stop mode");

	// main scenarios
	cov_irq_done: cover property (@(posedge pclk) disable iff (!presetn)
		done_evt && done_irq_enable);
	cov_cont_twice: cover property (@(posedge pclk) disable iff (!presetn)
		restart ##[1:400] restart);
	cov_lock_drop: cover property (@(posedge pclk) disable iff (!presetn)
		done_evt && rd_lock && interlocked);
	cov_stop_abort: cover property (@(posedge pclk) disable iff (!presetn)
		converting && stop_mode);

endmodule : sacl_control

/* File: hdl/sacl_pkg.sv */
// shared constants and types for the converter control block
package sacl_pkg;
	// register byte offsets on the apb bus
	localparam logic [11:0] OFF_STATUS_CONTROL = 12'h000;
	localparam logic [11:0] OFF_RESULT_HIGH = 12'h004;
	localparam logic [11:0] OFF_RESULT_LOW = 12'h008;
	localparam logic [11:0] OFF_CLOCK_CONFIG = 12'h00c;
	// status and control field positions
	localparam int SCR_DONE_BIT = 7;
	localparam int SCR_IRQ_EN_BIT = 6;
	localparam int SCR_CONT_BIT = 5;
	localparam int SCR_CHAN_MSB = 4;
	// clock config field positions
	localparam int CFG_DIV_MSB = 7;
	localparam int CFG_DIV_LSB = 5;
	localparam int CFG_SRC_BIT = 4;
	localparam int CFG_FMT_MSB = 3;
	localparam int CFG_FMT_LSB = 2;
	// reset values
	localparam logic [4:0] CHAN_RESET = 5'h1f;
	localparam logic [7:0] CFG_RESET = 8'h04;
	// channel codes
	localparam logic [4:0] CH_EXT_LAST = 5'h17;
	localparam logic [4:0] CH_HIGH_REF = 5'h1d;
	localparam logic [4:0] CH_LOW_REF = 5'h1e;
	localparam logic [4:0] CH_POWER_OFF = 5'h1f;
	// conversion length in converter clock cycles
	localparam logic [4:0] CONV_MIN_CYC = 5'h10;
	localparam logic [4:0] CONV_MAX_CYC = 5'h11;
	// prescaler terminal counts
	localparam logic [3:0] DIV1_TERM = 4'h0;
	localparam logic [3:0] DIV2_TERM = 4'h1;
	localparam logic [3:0] DIV4_TERM = 4'h3;
	localparam logic [3:0] DIV8_TERM = 4'h7;
	localparam logic [3:0] DIV16_TERM = 4'hf;

	typedef enum logic [1:0] {
		FMT_TRUNC = 2'h0,
		FMT_RIGHT = 2'h1,
		FMT_LEFT = 2'h2,
		FMT_SIGNED = 2'h3
	} sacl_fmt_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} sacl_state_t;

	// analog input routing handed to the converter core
	typedef struct packed {
		logic power_on;
		logic sel_ext;
		logic sel_high_ref;
		logic sel_low_ref;
		logic [4:0] channel;
	} sacl_route_t;
endpackage : sacl_pkg

/* File: test/sacl_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sacl_control_tb;
	localparam logic [11:0] A_SC = sacl_pkg::OFF_STATUS_CONTROL;
	localparam logic [11:0] A_HI = sacl_pkg::OFF_RESULT_HIGH;
	localparam logic [11:0] A_LO = sacl_pkg::OFF_RESULT_LOW;
	localparam logic [11:0] A_CF = sacl_pkg::OFF_CLOCK_CONFIG;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic osc, stop_mode, core_conv_tick, core_start, core_done, conv_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [9:0] core_result, value;
	logic [7:0] rd;
	sacl_pkg::sacl_route_t core_route;
	int fails = 0;
	int checked = 0;
	int starts = 0;

	// block and its converter core
	sacl_control dut_u (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.oscillator_out_clock(osc),
		.stop_mode(stop_mode),
		.core_conv_tick(core_conv_tick),
		.core_start(core_start),
		.core_route(core_route),
		.core_result(core_result),
		.core_done(core_done),
		.conv_irq(conv_irq)
	);
	sacl_core_model core_u (
		.pclk(pclk),
		.presetn(presetn),
		.core_start(core_start),
		.core_conv_tick(core_conv_tick),
		.value(value),
		.core_result(core_result),
		.core_done(core_done)
	);

	// bus clock, and an oscillator of eight bus cycles, phase unrelated
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial
	begin
		osc = 1'b0;
		#37;
		forever #400 osc = ~osc;
	end
	// conversion starts seen at the core
	always @(posedge pclk)
		if (core_start === 1'b1)
			starts <= starts + 1;

	// verdict and run end
	task final_report();
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask : final_report
	task hang();
		begin
			fails++;
			final_report();
		end
	endtask : hang
	task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] g);
		begin
			checked++;
			if (g !== e)
			begin
				fails++;
				$display("mismatch %s exp %h got %h", nm, e, g);
			end
		end
	endtask : cmp
	// one apb transfer, then an idle edge so no signal is set twice at once
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		begin
			n = 0;
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h000000, d};
			@(posedge pclk);
			penable <= 1'b1;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (pready !== 1'b1 && n < 9);
			if (n >= 9)
				hang();
			rd = prdata[7:0];
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask : xfer
	task automatic scr(input logic [7:0] d);
		xfer(1'b1, A_SC, {1'b0, d[6:0]});
	endtask : scr
	task automatic rdc(input logic [11:0] a, input logic [9:0] e);
		begin
			xfer(1'b0, a, 8'h00);
			cmp($sformatf("reg %h", a), e, rd);
		end
	endtask : rdc
	// bounded waits: done flag by polling, irq or tick by sampling
	task automatic wait_done();
		int n;
		begin
			n = 0;
			do
			begin
				xfer(1'b0, A_SC, 8'h00);
				n++;
			end
			while (rd[7] !== 1'b1 && n < 200);
			if (n >= 200)
				hang();
		end
	endtask : wait_done
	task automatic wait_hi(input int k);
		int n;
		begin
			n = 0;
			while ((k ? core_conv_tick : conv_irq) !== 1'b1 && n < 400)
			begin
				@(posedge pclk);
				n++;
			end
			if (n >= 400)
				hang();
		end
	endtask : wait_hi
	// second tick gap, clear of any prescaler phase left from before
	task automatic gap(output int n);
		begin
			wait_hi(1);
			repeat (2)
			begin
				n = 0;
				do
				begin
					@(posedge pclk);
					n++;
				end
				while (core_conv_tick !== 1'b1 && n < 40);
			end
		end
	endtask : gap

	// scenarios
	task automatic t_reset();
		begin
			rdc(A_SC, 8'h1f);
			rdc(A_CF, 8'h04);
			rdc(A_HI, 8'h00);
			rdc(A_LO, 8'h00);
			xfer(1'b0, 12'h010, 8'h00);
			cmp("slverr", 10'h001, er);
		end
	endtask : t_reset
	task automatic t_formats();
		logic [7:0] ehi[4] = '{8'h00, 8'h02, 8'hb5, 8'h35};
		logic [7:0] elo[4] = '{8'hb5, 8'hd6, 8'h80, 8'h80};
		int s;
		begin
			for (int f = 0; f < 4; f++)
			begin
				s = starts;
				xfer(1'b1, A_CF, {4'h1, f[1:0], 2'h0});
				scr(8'h05);
				wait_done();
				rdc(A_HI, ehi[f]);
				rdc(A_LO, elo[f]);
				rdc(A_SC, 8'h05);
				repeat (40) @(posedge pclk);
				cmp("starts", 10'h001, 10'(starts - s));
			end
			// later scenarios expect right format on the bus clock, divide by one
			xfer(1'b1, A_CF, 8'h14);
		end
	endtask : t_formats
	task automatic t_irq();
		begin
			scr(8'h45);
			wait_hi(0);
			rdc(A_SC, 8'h45);
			rdc(A_LO, 8'hd6);
			cmp("irq", 10'h000, conv_irq);
			scr(8'h45);
			wait_hi(0);
			scr(8'h05);
			cmp("irq", 10'h000, conv_irq);
			wait_done();
			rdc(A_LO, 8'hd6);
		end
	endtask : t_irq
	task automatic t_lock();
		begin
			scr(8'h05);
			wait_done();
			rdc(A_HI, 8'h02);
			value <= 10'h129;
			scr(8'h05);
			wait_done();
			rdc(A_LO, 8'hd6);
			rdc(A_HI, 8'h02);
			rdc(A_LO, 8'hd6);
		end
	endtask : t_lock
	task automatic t_cont();
		int s;
		begin
			value <= 10'h2d6;
			scr(8'h25);
			wait_done();
			rdc(A_LO, 8'hd6);
			value <= 10'h129;
			wait_done();
			rdc(A_HI, 8'h01);
			rdc(A_LO, 8'h29);
			scr(8'h05);
			wait_done();
			rdc(A_LO, 8'h29);
			s = starts;
			repeat (40) @(posedge pclk);
			cmp("starts", 10'h000, 10'(starts - s));
		end
	endtask : t_cont
	task automatic t_chan();
		logic [4:0] codes[5] = '{5'h00, 5'h10, 5'h17, 5'h1d, 5'h1e};
		logic [4:0] c;
		int s;
		begin
			foreach (codes[i])
			begin
				c = codes[i];
				scr({3'h0, c});
				@(posedge pclk);
				cmp("route", {2'h1, c <= 5'h17, c == 5'h1d, c == 5'h1e, c}, core_route);
			end
			scr(8'h1f);
			s = starts;
			repeat (40) @(posedge pclk);
			cmp("power", 10'h000, core_route.power_on);
			cmp("starts", 10'h000, 10'(starts - s));
			scr(8'h05);
			@(posedge pclk);
			cmp("power", 10'h001, core_route.power_on);
			// first result after power-up is stored like any other
			repeat (40) @(posedge pclk);
			rdc(A_LO, 8'h29);
		end
	endtask : t_chan
	task automatic t_stop();
		int s;
		begin
			s = starts;
			scr(8'h05);
			stop_mode <= 1'b1;
			repeat (40) @(posedge pclk);
			rdc(A_SC, 8'h05);
			scr(8'h05);
			@(posedge pclk);
			cmp("starts", 10'h001, 10'(starts - s));
			stop_mode <= 1'b0;
		end
	endtask : t_stop
	task automatic t_clk();
		logic [2:0] dv[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		int ex[6] = '{1, 2, 4, 8, 16, 16};
		int n;
		begin
			// divide by 8 keeps the converter near 1 mhz
			foreach (dv[i])
			begin
				xfer(1'b1, A_CF, {dv[i], 5'h14});
				scr(8'h05);
				gap(n);
				cmp("tick gap", 10'(ex[i]), 10'(n));
			end
			xfer(1'b1, A_CF, 8'h04);
			scr(8'h05);
			gap(n);
			cmp("osc gap", 10'h008, 10'(n));
		end
	endtask : t_clk

	// reset, then the scenarios in turn
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		stop_mode = 1'b0;
		value = 10'h2d6;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_formats();
		t_irq();
		t_lock();
		t_cont();
		t_chan();
		t_stop();
		t_clk();
		final_report();
	end
endmodule : sacl_control_tb

/* File: test/sacl_core_model.sv */
// converter core stand-in: answers each start after sixteen ticks
`timescale 1ns/1ps
module sacl_core_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control side
	input wire logic core_start,
	input wire logic core_conv_tick,
	input wire logic [9:0] value,
	// answer
	output logic [9:0] core_result,
	output logic core_done
);
	logic [4:0] ticks;
	logic busy;

	// tick counter; a tick in the start cycle already counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			ticks <= 5'h00;
			core_done <= 1'b0;
		end
		else
		begin
			core_done <= 1'b0;
			if (core_start)
			begin
				busy <= 1'b1;
				ticks <= {4'h0, core_conv_tick};
			end
			else if (busy && core_conv_tick)
			begin
				ticks <= ticks + 5'h01;
				if (ticks == 5'h0f)
				begin
					busy <= 1'b0;
					core_done <= 1'b1;
				end
			end
		end
	end
	// inverted outside the strobe so a late sample shows up
	assign core_result = core_done ? value : ~value;
endmodule : sacl_core_model
